/* logic/pdl_pkg.sv */
// What this block does
// - One quad 3 diagnostic register reports the selected lane
// - Two-bit select picks lane zero to three
// - Pattern mismatch captures the expected byte
// - Pattern mismatch captures the received byte
// - Error count saturates at 255, clears disabled
// - Clearing pattern enable clears the count while PRBS enable is off
// - Clearing PRBS enable clears the count while pattern enable is off
// - Source flag: 0 pattern, 1 PRBS
// - Per-port saturating receiver error byte counters
// - Any byte write clears that port counter
// - First Configuration-to-L0 loads negotiated width
// - Inactive port target width stays zero
// - Port zero five-bit sticky writable target
// - Upconfigure capability flag follows partner training
// - Retrain with changed width renegotiates width
package pdl_pkg;

   // Register access port geometry.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NPORT  = 4;
   localparam int NLANE  = 4;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFF_QUAD3_DIAG = 12'h244;
   localparam logic [ADDR_W-1:0] OFF_RX_ERR     = 12'h248;
   localparam logic [ADDR_W-1:0] OFF_LINK_WIDTH = 12'h24C;

   // Quad diagnostic field layout.
   localparam int DIAG_EXP_LSB = 0;
   localparam int DIAG_ACT_LSB = 8;
   localparam int DIAG_CNT_LSB = 16;
   localparam int DIAG_SEL_LSB = 24;
   localparam int DIAG_SRC_BIT = 30;
   localparam int SEL_W        = 2;
   localparam int CNT_W        = 8;

   // Link width register layout, one byte per port.
   localparam int TGT_W        = 5;
   localparam int CAP_BIT_OFS  = 7;
   localparam int NEG_W        = 6;
   localparam logic [TGT_W-1:0] TGT_MASK [NPORT] = '{5'h1F, 5'h0F, 5'h07, 5'h07};

   // Reset values.
   localparam logic [SEL_W-1:0]  RST_SEL  = 2'h0;
   localparam logic [7:0]        RST_BYTE = 8'h00;
   localparam logic [TGT_W-1:0]  RST_TGT  = 5'h00;

   // One register access request.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        be;
   } pdl_req_type;

   // Checker results of one lane.
   typedef struct packed {
      logic       utp_err;
      logic       prbs_err;
      logic [7:0] exp_byte;
      logic [7:0] act_byte;
   } pdl_lane_type;

   // Training and error status of one port.
   typedef struct packed {
      logic             active;
      logic             cfg_to_l0;
      logic [NEG_W-1:0] neg_width;
      logic             cap_valid;
      logic             cap_seen;
      logic             retrain_req;
      logic             rx_err;
   } pdl_port_type;

endpackage

/* logic/pdl_sat_count.sv */
`timescale 1ns/1ps
module pdl_sat_count #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Control.
   input  wire logic         inc,
   input  wire logic         clr,
   // Count.
   output logic [W-1:0]      count
);

   typedef struct packed {
      logic [W-1:0] count;
   } pdl_cnt_state_type;

   pdl_cnt_state_type st_r;
   pdl_cnt_state_type st_nxt;

   // An event in the clearing cycle still counts, so the clear yields one, not zero.
   always_comb begin
      st_nxt = st_r;
      if (clr) begin
         st_nxt.count = inc ? W'(1) : '0;
      end else if (inc && (st_r.count != {W{1'b1}})) begin
         st_nxt.count = st_r.count + W'(1);
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.count;

endmodule // pdl_sat_count

/* logic/pdl_regs.sv */
`timescale 1ns/1ps
module pdl_regs (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Register access.
   input  wire pdl_pkg::pdl_req_type         req,
   output logic [pdl_pkg::DATA_W-1:0]        rdata,
   output logic                              rvalid,
   // Quad 3 lane checkers and their enables.
   input  wire pdl_pkg::pdl_lane_type        lane [pdl_pkg::NLANE],
   input  wire logic                         utp_enable,
   input  wire logic                         prbs_enable,
   // Port training status.
   input  wire pdl_pkg::pdl_port_type        port [pdl_pkg::NPORT],
   // Width renegotiation request to the training logic.
   output logic [pdl_pkg::NPORT-1:0]         renegotiate
);

   typedef struct packed {
      logic [pdl_pkg::SEL_W-1:0]                      sel;
      logic [7:0]                                     exp_byte;
      logic [7:0]                                     act_byte;
      logic                                           src_prbs;
      logic [pdl_pkg::NPORT-1:0][pdl_pkg::TGT_W-1:0]  tgt;
      logic [pdl_pkg::NPORT-1:0]                      loaded;
      logic [pdl_pkg::NPORT-1:0]                      cap;
      logic [pdl_pkg::NPORT-1:0]                      reneg;
      logic [pdl_pkg::DATA_W-1:0]                     rdata;
      logic                                           rvalid;
   } pdl_state_type;

   pdl_state_type st_r;
   pdl_state_type st_nxt;

   logic [pdl_pkg::CNT_W-1:0]              diag_cnt;
   logic [pdl_pkg::NPORT-1:0][7:0]         rx_cnt;
   logic [pdl_pkg::NPORT-1:0]              rx_clr;
   logic                                   diag_inc;
   logic                                   diag_clr;
   logic                                   hit_diag;
   logic                                   hit_rx;
   logic                                   hit_width;
   pdl_pkg::pdl_lane_type                  sel_lane;

   // Address decode; an unmapped offset reads zero and drops writes.
   assign hit_diag  = (req.addr == pdl_pkg::OFF_QUAD3_DIAG);
   assign hit_rx    = (req.addr == pdl_pkg::OFF_RX_ERR);
   assign hit_width = (req.addr == pdl_pkg::OFF_LINK_WIDTH);

   // Only the lane named by the select field feeds the checker fields.
   assign sel_lane = lane[st_r.sel];

   // The count follows the PRBS checker when it runs, else the pattern checker; turning both off clears it.
   assign diag_clr = !(utp_enable || prbs_enable);
   assign diag_inc = prbs_enable ? sel_lane.prbs_err : (utp_enable && sel_lane.utp_err);

   // Pattern or PRBS error counter of the selected lane.
   pdl_sat_count #(
      .W (pdl_pkg::CNT_W)
   ) u_diag_cnt (
      .clk   (clk),
      .rst   (rst),
      .inc   (diag_inc),
      .clr   (diag_clr),
      .count (diag_cnt)
   );

   // One receiver error counter per port, cleared by a write to its byte.
   for (genvar p = 0; p < pdl_pkg::NPORT; p++) begin : g_rx
      assign rx_clr[p] = req.wr && hit_rx && req.be[p];
      pdl_sat_count #(
         .W (8)
      ) u_rx_cnt (
         .clk   (clk),
         .rst   (rst),
         .inc   (port[p].rx_err),
         .clr   (rx_clr[p]),
         .count (rx_cnt[p])
      );
   end

   // Next state: captures, width fields, retrain check and read data.
   always_comb begin
      st_nxt        = st_r;
      st_nxt.reneg  = '0;
      st_nxt.rvalid = req.rd;

      // Lane select write; bits above it in that byte are reserved, except the read-only source flag at bit 30.
      if (req.wr && hit_diag && req.be[3]) begin
         st_nxt.sel = req.wdata[pdl_pkg::DIAG_SEL_LSB +: pdl_pkg::SEL_W];
      end

      // Capture the byte pair of the selected lane on each pattern mismatch while PRBS is off.
      if (utp_enable && !prbs_enable && sel_lane.utp_err) begin
         st_nxt.exp_byte = sel_lane.exp_byte;
         st_nxt.act_byte = sel_lane.act_byte;
      end

      // Source flag tracks the checker feeding the count.
      st_nxt.src_prbs = prbs_enable;

      for (int p = 0; p < pdl_pkg::NPORT; p++) begin
         // Software writes the target of an active port, masked by that port's TGT_MASK.
         if (req.wr && hit_width && req.be[p]) begin
            st_nxt.tgt[p] = req.wdata[p*8 +: pdl_pkg::TGT_W] & pdl_pkg::TGT_MASK[p];
         end
         // The first entry to L0 wins over a write in the same cycle.
         if (port[p].cfg_to_l0 && !st_r.loaded[p]) begin
            st_nxt.tgt[p]    = pdl_pkg::TGT_W'(port[p].neg_width) & pdl_pkg::TGT_MASK[p];
            st_nxt.loaded[p] = 1'b1;
         end
         // An inactive port holds zero and forgets its first load.
         if (!port[p].active) begin
            st_nxt.tgt[p]    = pdl_pkg::RST_TGT;
            st_nxt.loaded[p] = 1'b0;
         end
         // Capability follows what the partner showed in the last training.
         if (port[p].cap_valid) begin
            st_nxt.cap[p] = port[p].cap_seen;
         end
         // A retrain to a different width sends the link back through Configuration.
         if (port[p].retrain_req && port[p].active &&
             (pdl_pkg::NEG_W'(st_r.tgt[p]) != port[p].neg_width)) begin
            st_nxt.reneg[p] = 1'b1;
         end
      end

      // Read mux; every bit not listed reads zero.
      st_nxt.rdata = '0;
      if (req.rd) begin
         if (hit_diag) begin
            st_nxt.rdata[pdl_pkg::DIAG_EXP_LSB +: 8] = st_r.exp_byte;
            st_nxt.rdata[pdl_pkg::DIAG_ACT_LSB +: 8] = st_r.act_byte;
            st_nxt.rdata[pdl_pkg::DIAG_CNT_LSB +: pdl_pkg::CNT_W] = diag_cnt;
            st_nxt.rdata[pdl_pkg::DIAG_SEL_LSB +: pdl_pkg::SEL_W] = st_r.sel;
            st_nxt.rdata[pdl_pkg::DIAG_SRC_BIT] = st_r.src_prbs;
         end else if (hit_rx) begin
            st_nxt.rdata = rx_cnt;
         end else if (hit_width) begin
            for (int p = 0; p < pdl_pkg::NPORT; p++) begin
               st_nxt.rdata[p*8 +: pdl_pkg::TGT_W] = st_r.tgt[p];
               st_nxt.rdata[p*8 + pdl_pkg::CAP_BIT_OFS] = st_r.cap[p];
            end
         end
      end
   end

   // State register; every field resets with rst; all but rdata, rvalid, reneg and src_prbs hold their value, the target fields included.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register.
   assign rdata       = st_r.rdata;
   assign rvalid      = st_r.rvalid;
   assign renegotiate = st_r.reneg;

endmodule // pdl_regs

/* verif/pdl_regs_properties.sv */
`timescale 1ns/1ps
module pdl_regs_chk (
   // Clock and reset.
   input wire logic                      clk,
   input wire logic                      rst,
   // Register access.
   input wire pdl_pkg::pdl_req_type      req,
   input wire logic [pdl_pkg::DATA_W-1:0] rdata,
   input wire logic                      rvalid,
   // Checkers and training.
   input wire pdl_pkg::pdl_lane_type     lane [pdl_pkg::NLANE],
   input wire logic                      utp_enable,
   input wire logic                      prbs_enable,
   input wire pdl_pkg::pdl_port_type     port [pdl_pkg::NPORT],
   input wire logic [pdl_pkg::NPORT-1:0] renegotiate
);
   logic [11:0] last_a;
   logic        rd_dg;
   logic        rd_lw;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Remember which offset the answer in flight belongs to.
   always_ff @(posedge clk) last_a <= req.addr;
   assign rd_dg = rvalid && last_a == pdl_pkg::OFF_QUAD3_DIAG;
   assign rd_lw = rvalid && last_a == pdl_pkg::OFF_LINK_WIDTH;

   // Bus timing and reserved bits; reserved bits must never leak ones.
   a_read_answer: assert property (req.rd |=> rvalid)
      else $error("read not answered");
   a_idle_zero: assert property (!rvalid |-> rdata == '0)
      else $error("read data not at rest");
   a_diag_rsvd: assert property (rd_dg |-> rdata[31] == 1'b0 && rdata[29:26] == 4'h0)
      else $error("diag reserved bits set");
   a_width_rsvd: assert property (rd_lw |-> (rdata & 32'h78787060) == '0)
      else $error("width reserved bits set");
   // The source flag read back lags the PRBS enable by two register stages.
   a_src_flag: assert property (rd_dg |-> rdata[30] == $past(prbs_enable, 2))
      else $error("source flag wrong");
   a_cnt_clear: assert property ((!utp_enable && !prbs_enable)[*2] ##0
      (req.rd && req.addr == pdl_pkg::OFF_QUAD3_DIAG) |=> rdata[23:16] == 8'h00)
      else $error("count not cleared");
   a_rx_clear: assert property (req.wr && req.addr == pdl_pkg::OFF_RX_ERR && req.be[0]
      && !port[0].rx_err ##1 !port[0].rx_err ##1 req.rd && !req.wr
      && req.addr == pdl_pkg::OFF_RX_ERR |=> rdata[7:0] == 8'h00)
      else $error("rx count not cleared");
   a_idle_port: assert property (rd_lw && !$past(port[3].active, 2)
      && !$past(port[3].active) |-> rdata[26:24] == 3'h0)
      else $error("inactive target not zero");
   a_reneg_cause: assert property (renegotiate[0] |-> $past(port[0].retrain_req)
      && $past(port[0].active))
      else $error("renegotiate without cause");

   // Main scenarios reached.
   cover property (renegotiate[0]);
   cover property (rd_dg && rdata[23:16] == 8'hFF);
   cover property (req.wr && req.addr == pdl_pkg::OFF_RX_ERR);
endmodule // pdl_regs_chk

bind pdl_regs pdl_regs_chk pdl_regs_chk_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
   .rvalid(rvalid), .lane(lane), .utp_enable(utp_enable), .prbs_enable(prbs_enable),
   .port(port), .renegotiate(renegotiate));

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   pdl_pkg::pdl_req_type  req = '0;
   logic [31:0]           rdata;
   logic                  rvalid;
   pdl_pkg::pdl_lane_type lane [pdl_pkg::NLANE] = '{default: '0};
   logic                  utp_enable = 1'b0;
   logic                  prbs_enable = 1'b0;
   pdl_pkg::pdl_port_type port [pdl_pkg::NPORT] = '{default: '0};
   logic [3:0]            renegotiate;
   logic [15:0]           seed = 16'h0005;
   logic [31:0]           d;
   logic [31:0]           x;
   int                    c [4];
   int                    n_errors = 0;
   int                    n_compared = 0;
   int                    cyc = 0;

   always #2.5 clk = ~clk;

   pdl_regs pdl_regs_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .lane(lane), .utp_enable(utp_enable), .prbs_enable(prbs_enable), .port(port),
      .renegotiate(renegotiate));

   // Pseudo-random source and the expected width byte of one port.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] wbyte(input logic cap, input logic [5:0] w, input int p);
      return {cap, 2'h0, w[4:0] & pdl_pkg::TGT_MASK[p]};
   endfunction

   // Comparison, register access and the closing report.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a);
      @(negedge clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      d = rdata;
      chk(32'(rvalid), 32'h1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] b);
      @(negedge clk);
      req = '{1'b1, 1'b0, a, w, b};
      @(negedge clk);
      req.wr = 1'b0;
   endtask
   task automatic results();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // A hang is cut short well beyond the expected run length.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(12'h244 + 12'(4 * i));
         chk(d, '0);
      end
      // Each lane code in turn; every lane errs with distinct bytes.
      for (int s = 0; s < 4; s++) begin
         seed = lfsr(seed);
         utp_enable = 1'b1;
         wr(pdl_pkg::OFF_QUAD3_DIAG, {6'h3F, 2'(s), 24'hFFFFFF}, 4'hF);
         repeat (s + 1) begin
            @(negedge clk);
            for (int l = 0; l < 4; l++) begin
               lane[l] = '{1'b1, 1'b0, seed[7:0] ^ 8'(l), seed[15:8] ^ 8'(l)};
            end
            @(negedge clk);
            for (int l = 0; l < 4; l++) lane[l].utp_err = 1'b0;
         end
         rd(pdl_pkg::OFF_QUAD3_DIAG);
         chk(d, {6'h0, 2'(s), 8'(s + 1), seed ^ {2{8'(s)}}});
         utp_enable = 1'b0;
         rd(pdl_pkg::OFF_QUAD3_DIAG);
         chk(32'(d[23:16]), 32'h0);
      end
      // PRBS errors on lane 3 run past the saturation point.
      prbs_enable = 1'b1;
      lane[3].prbs_err = 1'b1;
      repeat (260) @(negedge clk);
      lane[3].prbs_err = 1'b0;
      rd(pdl_pkg::OFF_QUAD3_DIAG);
      chk(32'(d[31:16]), 32'h43FF);
      prbs_enable = 1'b0;
      rd(pdl_pkg::OFF_QUAD3_DIAG);
      chk(32'(d[23:16]), 32'h0);
      // Receiver errors per port, then a write clears two bytes.
      c = '{300, seed[5:0], seed[11:6], 255};
      for (int i = 0; i <= 300; i++) begin
         @(negedge clk);
         for (int p = 0; p < 4; p++) port[p].rx_err = (i < c[p]);
      end
      rd(pdl_pkg::OFF_RX_ERR);
      chk(d, {8'hFF, 8'(c[2]), 8'(c[1]), 8'hFF});
      wr(pdl_pkg::OFF_RX_ERR, {seed, seed}, 4'b0101);
      rd(pdl_pkg::OFF_RX_ERR);
      chk(d, {8'hFF, 8'h00, 8'(c[1]), 8'h00});
      // Two trainings: only the first loads the width; capability follows the last.
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         for (int p = 0; p < 4; p++) begin
            port[p] = '{p < 3, 1'b1, seed[5:0] ^ 6'(p) ^ {6{k[0]}},
                        p < 3, p[0] ^ k[0], 1'b0, 1'b0};
            x[8 * p +: 8] = (p < 3) ? wbyte(!p[0], seed[5:0] ^ 6'(p), p) : 8'h00;
         end
         @(negedge clk);
         for (int p = 0; p < 4; p++) port[p].cfg_to_l0 = 1'b0;
         for (int p = 0; p < 4; p++) port[p].cap_valid = 1'b0;
      end
      rd(pdl_pkg::OFF_LINK_WIDTH);
      chk(d, x);
      wr(pdl_pkg::OFF_LINK_WIDTH, 32'hFF00007F, 4'h9);
      x[7:0] = 8'h9F;
      rd(pdl_pkg::OFF_LINK_WIDTH);
      chk(d, x);
      // Retrain toward a different width, then toward the same width.
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         port[0].neg_width = k ? 6'h1F : 6'h04;
         port[0].retrain_req = 1'b1;
         port[3].retrain_req = 1'b1;
         @(negedge clk);
         port[0].retrain_req = 1'b0;
         port[3].retrain_req = 1'b0;
         chk(32'(renegotiate), k ? 32'h0 : 32'h1);
      end
      results();
   end
endmodule // tb
